/* File: rtl/uart_stat_pkg.sv */
// Purpose: constants and types shared by the line/modem status block
// Assumes: apb with 32-bit data, one aligned word per register
// Notes:   all register offsets are byte addresses
package uart_stat_pkg;
    // ----------------------------------------
    // register map (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] ADDR_DATA    = 8'h00;
    localparam logic [7:0] ADDR_IENABLE = 8'h04;
    localparam logic [7:0] ADDR_FIFOCTL = 8'h08;
    localparam logic [7:0] ADDR_MODEM_C = 8'h10;
    localparam logic [7:0] ADDR_LINE_ST = 8'h14;
    localparam logic [7:0] ADDR_MODEM_S = 8'h18;
    localparam logic [7:0] ADDR_SCRATCH = 8'h1c;
    localparam logic [7:0] ADDR_FEATURE = 8'h20;
    localparam logic [7:0] ADDR_ENHFUNC = 8'h24;
    // ----------------------------------------
    // field positions and reset values
    // ----------------------------------------
    localparam int          MC_LOOP      = 4;
    localparam int          MC_PRESCALE  = 7;
    localparam int          EF_ENHANCED  = 4;
    localparam int          IE_MODEM     = 3;
    localparam int          FC_SWAP      = 6;
    localparam int          FIFO_EN_BIT  = 0;
    localparam logic [7:0]  SCRATCH_RST  = 8'hff;
    localparam logic [7:0]  ZERO_RST     = 8'h00;
    localparam logic [1:0]  PRESCALE_DIV = 2'h3;
    // ----------------------------------------
    // fifo geometry
    // ----------------------------------------
    localparam int          FIFO_DEPTH   = 16;
    localparam int          PTR_W        = 4;
    localparam int          CNT_W        = 5;
    localparam logic [4:0]  CNT_FULL     = 5'h10;
    localparam logic [4:0]  CNT_ONE      = 5'h01;
    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef struct packed {
        logic       brk;
        logic       ferr;
        logic       perr;
        logic [7:0] data;
    } rx_char_s;
endpackage

/* File: rtl/uart_line_modem_status_regs.sv */
// Purpose: line status, modem status, scratch/level swap and prescale select
// Assumes: receiver and transmitter shifters run on mclk_i and hand over chars here
// Notes:   apb slave with one wait state; unmapped addresses answer pslverr
//
// What this block does
// - prescale select divides clock by four
// - data ready while receive store holds data
// - overrun flags, full fifo keeps its data
// - parity error follows character at head
// - framing error follows character at head
// - one break character per break condition
// - holding-empty follows transmit store emptiness
// - idle when store and shifter empty
// - fifo error while any entry errs
// - modem deltas set on change, interrupt
// - ring delta only at ringing end
// - loopback status mirrors modem control bits
// - scratch store resets to all ones
// - swap routes writes and level reads
// - mode bits pick receive, transmit, alternate
// - alternate mode starts with receive count
// - four-bit code selects hysteresis count
// - level readout follows count select
// - loopback enable routes control to status
`timescale 1ns/1ps
module uart_line_modem_status_regs (
    // clock and reset
    input  wire logic                    mclk_i,
    input  wire logic                    reset_i,
    // apb slave
    input  wire logic                    psel_i,
    input  wire logic                    penable_i,
    input  wire logic                    pwrite_i,
    input  wire logic [7:0]              paddr_i,
    input  wire logic [31:0]             pwdata_i,
    output logic                         pready_o,
    output logic [31:0]                  prdata_o,
    output logic                         pslverr_o,
    // receive shifter
    input  wire logic                    rx_done_i,
    input  wire uart_stat_pkg::rx_char_s rx_char_i,
    // transmit shifter
    input  wire logic                    tx_take_i,
    input  wire logic                    tx_shift_busy_i,
    output logic                         tx_avail_o,
    output logic [7:0]                   tx_data_o,
    // baud generator and flow control
    output logic                         baud_tick_o,
    output logic [5:0]                   hysteresis_o,
    output logic                         modem_irq_o
);
    // ----------------------------------------
    // registers and apb decode
    // ----------------------------------------
    logic [7:0] ienable_r, fifoctl_r, modem_ctl_r, feature_r, enhfunc_r;
    logic [7:0] scratch_r, emode_r;
    logic       pready_r, pslverr_r;
    logic [31:0] prdata_r;
    logic       fire, wr, rd, mapped;
    logic [7:0] rdmux;
    logic       fifo_en, swap;

    assign fire    = psel_i && penable_i && pready_r;
    assign wr      = fire && pwrite_i && mapped;
    assign rd      = fire && !pwrite_i && mapped;
    assign fifo_en = fifoctl_r[uart_stat_pkg::FIFO_EN_BIT];
    assign swap    = feature_r[uart_stat_pkg::FC_SWAP];

    always_comb begin
        case (paddr_i)
            uart_stat_pkg::ADDR_DATA, uart_stat_pkg::ADDR_IENABLE,
            uart_stat_pkg::ADDR_FIFOCTL, uart_stat_pkg::ADDR_MODEM_C,
            uart_stat_pkg::ADDR_LINE_ST, uart_stat_pkg::ADDR_MODEM_S,
            uart_stat_pkg::ADDR_SCRATCH, uart_stat_pkg::ADDR_FEATURE,
            uart_stat_pkg::ADDR_ENHFUNC: mapped = 1'b1;
            default:                     mapped = 1'b0;
        endcase
    end

    // one wait state: data is captured while pready is low
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            pready_r  <= 1'b0;
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else begin
            pready_r  <= psel_i && penable_i && !pready_r;
            if (psel_i && penable_i && !pready_r) begin
                prdata_r  <= pwrite_i ? 32'h0000_0000 : {24'h00_0000, rdmux};
                pslverr_r <= !mapped;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            ienable_r   <= uart_stat_pkg::ZERO_RST;
            fifoctl_r   <= uart_stat_pkg::ZERO_RST;
            modem_ctl_r <= uart_stat_pkg::ZERO_RST;
            feature_r   <= uart_stat_pkg::ZERO_RST;
            enhfunc_r   <= uart_stat_pkg::ZERO_RST;
        end else if (wr) begin
            case (paddr_i)
                uart_stat_pkg::ADDR_IENABLE: ienable_r <= pwdata_i[7:0];
                uart_stat_pkg::ADDR_FIFOCTL: fifoctl_r <= pwdata_i[7:0];
                uart_stat_pkg::ADDR_FEATURE: feature_r <= pwdata_i[7:0];
                uart_stat_pkg::ADDR_ENHFUNC: enhfunc_r <= pwdata_i[7:0];
                uart_stat_pkg::ADDR_MODEM_C: begin
                    modem_ctl_r[6:0] <= pwdata_i[6:0];
                    // prescale bit is locked unless enhanced functions are on
                    if (enhfunc_r[uart_stat_pkg::EF_ENHANCED]) begin
                        modem_ctl_r[7] <= pwdata_i[7];
                    end
                end
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // scratch store, mode select, alternate toggle
    // ----------------------------------------
    logic alt_tx_r;
    logic scr_wr, scr_rd;
    assign scr_wr = wr && paddr_i == uart_stat_pkg::ADDR_SCRATCH;
    assign scr_rd = rd && paddr_i == uart_stat_pkg::ADDR_SCRATCH;

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            scratch_r <= uart_stat_pkg::SCRATCH_RST;
            emode_r   <= uart_stat_pkg::ZERO_RST;
            alt_tx_r  <= 1'b0;
        end else if (scr_wr) begin
            if (swap) begin
                emode_r  <= pwdata_i[7:0];
                alt_tx_r <= 1'b0;
            end else begin
                scratch_r <= pwdata_i[7:0];
            end
        end else if (scr_rd && swap && emode_r[1:0] == 2'h3) begin
            alt_tx_r <= !alt_tx_r;
        end
    end

    // ----------------------------------------
    // receive fifo with per-entry tags
    // ----------------------------------------
    uart_stat_pkg::rx_char_s rx_mem [uart_stat_pkg::FIFO_DEPTH];
    logic [uart_stat_pkg::PTR_W-1:0] rx_wp_r, rx_rp_r;
    logic [uart_stat_pkg::CNT_W-1:0] rx_cnt_r, rx_cap;
    logic rx_full, rx_pop, rx_push, brk_seen_r, overrun_r;
    uart_stat_pkg::rx_char_s rx_head;

    assign rx_cap  = fifo_en ? uart_stat_pkg::CNT_FULL : uart_stat_pkg::CNT_ONE;
    assign rx_full = rx_cnt_r >= rx_cap;
    assign rx_head = rx_mem[rx_rp_r];
    assign rx_pop  = rd && paddr_i == uart_stat_pkg::ADDR_DATA && rx_cnt_r != '0;
    // a break char is stored only once until a normal char arrives
    assign rx_push = rx_done_i && !rx_full && !(rx_char_i.brk && brk_seen_r);

    always_ff @(posedge mclk_i) begin
        if (rx_push) begin
            rx_mem[rx_wp_r] <= rx_char_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            rx_wp_r  <= '0;
            rx_rp_r  <= '0;
            rx_cnt_r <= '0;
        end else begin
            if (rx_push) begin
                rx_wp_r <= rx_wp_r + 1'b1;
            end
            if (rx_pop) begin
                rx_rp_r <= rx_rp_r + 1'b1;
            end
            rx_cnt_r <= rx_cnt_r + (rx_push ? 5'h01 : 5'h00) - (rx_pop ? 5'h01 : 5'h00);
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            brk_seen_r <= 1'b0;
        end else if (rx_done_i) begin
            brk_seen_r <= rx_char_i.brk;
        end
    end

    // set wins over the clear by a status read
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            overrun_r <= 1'b0;
        end else if (rx_done_i && rx_full) begin
            overrun_r <= 1'b1;
        end else if (rd && paddr_i == uart_stat_pkg::ADDR_LINE_ST) begin
            overrun_r <= 1'b0;
        end
    end

    logic fifo_err;
    always_comb begin
        logic [uart_stat_pkg::PTR_W-1:0] idx;
        idx      = '0;
        fifo_err = 1'b0;
        for (int i = 0; i < uart_stat_pkg::FIFO_DEPTH; i++) begin
            idx = rx_rp_r + i[uart_stat_pkg::PTR_W-1:0];
            if (i < rx_cnt_r && (rx_mem[idx].brk || rx_mem[idx].ferr || rx_mem[idx].perr)) begin
                fifo_err = 1'b1;
            end
        end
    end

    // ----------------------------------------
    // transmit fifo
    // ----------------------------------------
    logic [7:0] tx_mem [uart_stat_pkg::FIFO_DEPTH];
    logic [uart_stat_pkg::PTR_W-1:0] tx_wp_r, tx_rp_r;
    logic [uart_stat_pkg::CNT_W-1:0] tx_cnt_r, tx_cnt_nxt;
    logic [uart_stat_pkg::PTR_W-1:0] tx_rp_nxt;
    logic tx_push, tx_pop;

    assign tx_push = wr && paddr_i == uart_stat_pkg::ADDR_DATA && tx_cnt_r < rx_cap;
    assign tx_pop  = tx_take_i && tx_avail_o;
    assign tx_cnt_nxt = tx_cnt_r + (tx_push ? 5'h01 : 5'h00) - (tx_pop ? 5'h01 : 5'h00);
    assign tx_rp_nxt  = tx_pop ? tx_rp_r + 1'b1 : tx_rp_r;

    always_ff @(posedge mclk_i) begin
        if (tx_push) begin
            tx_mem[tx_wp_r] <= pwdata_i[7:0];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            tx_wp_r    <= '0;
            tx_rp_r    <= '0;
            tx_cnt_r   <= '0;
            tx_avail_o <= 1'b0;
            tx_data_o  <= 8'h00;
        end else begin
            if (tx_push) begin
                tx_wp_r <= tx_wp_r + 1'b1;
            end
            tx_rp_r    <= tx_rp_nxt;
            tx_cnt_r   <= tx_cnt_nxt;
            tx_avail_o <= tx_cnt_nxt != '0;
            tx_data_o  <= (tx_push && tx_cnt_nxt == 5'h01) ? pwdata_i[7:0] : tx_mem[tx_rp_nxt];
        end
    end

    // ----------------------------------------
    // modem status through loopback
    // ----------------------------------------
    logic [3:0] mstat, mstat_prev_r, delta_r, delta_set;
    // outside loopback no modem pins exist, so the levels read zero
    assign mstat = modem_ctl_r[uart_stat_pkg::MC_LOOP] ?
                   {modem_ctl_r[3], modem_ctl_r[2], modem_ctl_r[0], modem_ctl_r[1]}
                   : 4'h0;
    assign delta_set[0] = mstat[0] ^ mstat_prev_r[0];
    assign delta_set[1] = mstat[1] ^ mstat_prev_r[1];
    // status bit is the inverse of the ring pin: pin rising is status falling
    assign delta_set[2] = mstat_prev_r[2] && !mstat[2];
    assign delta_set[3] = mstat[3] ^ mstat_prev_r[3];

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            mstat_prev_r <= 4'h0;
            delta_r      <= 4'h0;
        end else begin
            mstat_prev_r <= mstat;
            if (rd && paddr_i == uart_stat_pkg::ADDR_MODEM_S) begin
                delta_r <= delta_set;
            end else begin
                delta_r <= delta_r | delta_set;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            modem_irq_o <= 1'b0;
        end else begin
            modem_irq_o <= ienable_r[uart_stat_pkg::IE_MODEM] && |delta_r;
        end
    end

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    logic [7:0] line_st, level_rd;
    logic       head_ok;
    assign head_ok = rx_cnt_r != '0;
    assign line_st = {fifo_err,
                      tx_cnt_r == '0 && !tx_shift_busy_i,
                      tx_cnt_r == '0,
                      head_ok && rx_head.brk,
                      head_ok && rx_head.ferr,
                      head_ok && rx_head.perr,
                      overrun_r,
                      head_ok};
    assign level_rd = (!emode_r[0] || (emode_r[1] && !alt_tx_r)) ? {3'h0, rx_cnt_r}
                                                                 : {3'h0, tx_cnt_r};

    always_comb begin
        case (paddr_i)
            uart_stat_pkg::ADDR_DATA:    rdmux = head_ok ? rx_head.data : 8'h00;
            uart_stat_pkg::ADDR_IENABLE: rdmux = ienable_r;
            uart_stat_pkg::ADDR_FIFOCTL: rdmux = fifoctl_r;
            uart_stat_pkg::ADDR_MODEM_C: rdmux = modem_ctl_r;
            uart_stat_pkg::ADDR_LINE_ST: rdmux = line_st;
            uart_stat_pkg::ADDR_MODEM_S: rdmux = {mstat, delta_r};
            uart_stat_pkg::ADDR_SCRATCH: rdmux = swap ? level_rd : scratch_r;
            uart_stat_pkg::ADDR_FEATURE: rdmux = feature_r;
            uart_stat_pkg::ADDR_ENHFUNC: rdmux = enhfunc_r;
            default:                     rdmux = 8'h00;
        endcase
    end

    // ----------------------------------------
    // prescaler and hysteresis
    // ----------------------------------------
    logic [1:0] pre_cnt_r;
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            pre_cnt_r   <= 2'h0;
            baud_tick_o <= 1'b0;
        end else if (modem_ctl_r[uart_stat_pkg::MC_PRESCALE]) begin
            pre_cnt_r   <= pre_cnt_r + 2'h1;
            baud_tick_o <= pre_cnt_r == uart_stat_pkg::PRESCALE_DIV;
        end else begin
            pre_cnt_r   <= 2'h0;
            baud_tick_o <= 1'b1;
        end
    end

    function automatic logic [5:0] hyst(input logic [3:0] code);
        case (code)
            4'h0: hyst = 6'h00;  4'h1: hyst = 6'h04;  4'h2: hyst = 6'h06;  4'h3: hyst = 6'h08;
            4'h4: hyst = 6'h08;  4'h5: hyst = 6'h10;  4'h6: hyst = 6'h18;  4'h7: hyst = 6'h20;
            4'h8: hyst = 6'h28;  4'h9: hyst = 6'h2c;  4'ha: hyst = 6'h30;  4'hb: hyst = 6'h34;
            4'hc: hyst = 6'h0c;  4'hd: hyst = 6'h14;  4'he: hyst = 6'h1c;  default: hyst = 6'h24;
        endcase
    endfunction

    // reserved mode bits 3:2 are ignored; software keeps them zero
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            hysteresis_o <= 6'h00;
        end else begin
            hysteresis_o <= hyst({emode_r[5:4], feature_r[1:0]});
        end
    end

    assign pready_o  = pready_r;
    assign prdata_o  = prdata_r;
    assign pslverr_o = pslverr_r;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    // status read with no overrun arriving in the same cycle
    sequence s_lsr_read;
        rd && paddr_i == uart_stat_pkg::ADDR_LINE_ST && !(rx_done_i && rx_full);
    endsequence
    sequence s_full_arrival;
        rx_done_i && rx_full;
    endsequence
    sequence s_break_arrival;
        rx_done_i && rx_char_i.brk;
    endsequence

    // clearing the prescale bit ends the check, the tick then runs every cycle
    a_prescale_period: assert property (@(posedge mclk_i)
        disable iff (reset_i || !modem_ctl_r[uart_stat_pkg::MC_PRESCALE])
        modem_ctl_r[uart_stat_pkg::MC_PRESCALE] && baud_tick_o
        |=> !baud_tick_o [*3] ##1 baud_tick_o)
        else $error("prescaled tick not every fourth cycle");
    a_no_prescale: assert property (@(posedge mclk_i) disable iff (reset_i)
        !reset_i && !modem_ctl_r[7] ##1 !modem_ctl_r[7] |-> baud_tick_o)
        else $error("undivided tick missing");
    a_overrun_set: assert property (@(posedge mclk_i) disable iff (reset_i)
        s_full_arrival |=> overrun_r && ($stable(rx_cnt_r) || rx_cnt_r == $past(rx_cnt_r) - 5'h01))
        else $error("overrun not flagged or fifo changed");
    a_overrun_clear: assert property (@(posedge mclk_i) disable iff (reset_i)
        s_lsr_read |=> !overrun_r)
        else $error("overrun survives status read");
    a_ready_flag: assert property (@(posedge mclk_i) disable iff (reset_i)
        rx_push && !rx_pop |=> line_st[0])
        else $error("data ready not set after push");
    a_one_break: assert property (@(posedge mclk_i) disable iff (reset_i)
        s_break_arrival ##1 !rx_done_i ##1 s_break_arrival |-> !rx_push)
        else $error("second break char stored");
    a_thr_empty: assert property (@(posedge mclk_i) disable iff (reset_i)
        tx_push |=> !line_st[5] && !line_st[6])
        else $error("holding empty after load");
    a_ring_edge: assert property (@(posedge mclk_i) disable iff (reset_i)
        $rose(mstat[2]) && !(rd && paddr_i == uart_stat_pkg::ADDR_MODEM_S)
        |=> delta_r[2] == $past(delta_r[2]))
        else $error("ring delta set on wrong edge");
    a_alt_first_rx: assert property (@(posedge mclk_i) disable iff (reset_i)
        scr_wr && swap |=> !alt_tx_r)
        else $error("alternate mode not restarted on receive");
    a_modem_irq: assert property (@(posedge mclk_i) disable iff (reset_i)
        ienable_r[3] && delta_set != 4'h0 ##1 ienable_r[3] |=> modem_irq_o)
        else $error("modem interrupt missing");
endmodule

/* File: verif/uart_shifter_model.sv */
// Purpose: stand-in for the receive and transmit shifters
// Assumes: runs on the block clock
// Notes:   hold_i stalls the transmit take to let the store fill
`timescale 1ns/1ps
module uart_shifter_model (
    // clock and stall control
    input  wire logic               mclk_i,
    input  wire logic               hold_i,
    // block side
    input  wire logic               tx_avail_i,
    input  wire logic [7:0]         tx_data_i,
    output uart_stat_pkg::rx_char_s rx_char_o,
    output logic                    rx_done_o,
    output logic                    tx_take_o,
    output logic                    tx_busy_o
);
    logic [7:0] last_tx;
    int         left = 0;
    initial begin
        rx_done_o = 1'b0;
        rx_char_o = '0;
        tx_take_o = 1'b0;
    end
    task automatic send_char(input uart_stat_pkg::rx_char_s c);
        @(posedge mclk_i);
        rx_done_o <= 1'b1;
        rx_char_o <= c;
        @(posedge mclk_i);
        rx_done_o <= 1'b0;
        // no stale character outside the strobe
        rx_char_o <= ~c;
    endtask
    // slow shifter: one byte keeps it busy for 40 cycles
    always @(posedge mclk_i) begin
        if (tx_take_o) begin
            last_tx <= tx_data_i;
            left    <= 40;
        end else if (left > 0) begin
            left <= left - 1;
        end
        tx_take_o <= tx_avail_i && !hold_i && left == 0 && !tx_take_o;
    end
    assign tx_busy_o = left != 0;
endmodule

/* File: verif/tb_uart_line_modem_status_regs.sv */
// Purpose: self-checking bench for the line/modem status block
// Assumes: shifter model on the far side, apb master here
// Notes:   expectations come from bench functions and a fifo queue
`timescale 1ns/1ps
module tb_uart_line_modem_status_regs;
    logic        mclk, reset, psel, penable, pwrite, pready, pslverr, hold, e;
    logic        rx_done, tx_take, tx_busy, tx_avail, baud_tick, irq, brk_seen;
    logic [7:0]  paddr, tx_data, v;
    logic [31:0] pwdata, prdata, q;
    logic [5:0]  hyst;
    int          err_count = 0, compares = 0, n;
    uart_stat_pkg::rx_char_s rx_char, fq[$];
    logic [5:0]  htab[16] = '{0, 4, 6, 8, 8, 16, 24, 32, 40, 44, 48, 52, 12, 20, 28, 36};
    uart_line_modem_status_regs dut (.mclk_i(mclk), .reset_i(reset), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr), .rx_done_i(rx_done),
        .rx_char_i(rx_char), .tx_take_i(tx_take), .tx_shift_busy_i(tx_busy),
        .tx_avail_o(tx_avail), .tx_data_o(tx_data), .baud_tick_o(baud_tick),
        .hysteresis_o(hyst), .modem_irq_o(irq));
    uart_shifter_model model (.mclk_i(mclk), .hold_i(hold), .tx_avail_i(tx_avail),
        .tx_data_i(tx_data), .rx_char_o(rx_char), .rx_done_o(rx_done),
        .tx_take_o(tx_take), .tx_busy_o(tx_busy));
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    // --------------------------------
    // bus, checks and expectations
    // --------------------------------
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= {24'h0, d};
        @(posedge mclk);
        penable <= 1'b1;
        // only the watchdog ends a wait for the answer
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 8'h00);
        chk(q, exp);
    endtask
    function automatic logic [31:0] ls_exp(input logic ovr, input logic [1:0] tx);
        logic any = 1'b0;
        foreach (fq[i]) any |= fq[i].brk | fq[i].ferr | fq[i].perr;
        if (fq.size() == 0) return {25'h0, tx, 3'h0, ovr, 1'b0};
        return {24'h0, any, tx, fq[0].brk, fq[0].ferr, fq[0].perr, ovr, 1'b1};
    endfunction
    function automatic logic [31:0] hyst_exp(input logic [3:0] c);
        return {26'h0, htab[c]};
    endfunction
    task automatic push(input uart_stat_pkg::rx_char_s c);
        model.send_char(c);
        if (fq.size() < 16 && !(c.brk && brk_seen)) fq.push_back(c);
        brk_seen = c.brk;
    endtask
    task automatic pop();
        rd(uart_stat_pkg::ADDR_DATA, {24'h0, fq[0].data});
        void'(fq.pop_front());
    endtask
    task automatic ticks(input int exp);
        n = 0;
        repeat (8) begin
            @(posedge mclk);
            n += int'(baud_tick);
        end
        chk(n, exp);
    endtask
    task automatic complete_run();
        if (err_count == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        #400000;
        err_count++;
        complete_run();
    end
    // --------------------------------
    // main sequence
    // --------------------------------
    initial begin
        void'($urandom(32'h6c9b));
        {psel, penable, pwrite, hold, brk_seen} = '0;
        paddr = 8'h00;
        pwdata = 32'h0;
        reset = 1'b1;
        repeat (6) @(posedge mclk);
        reset <= 1'b0;
        rd(uart_stat_pkg::ADDR_SCRATCH, 32'hff);
        rd(uart_stat_pkg::ADDR_LINE_ST, ls_exp(1'b0, 2'b11));
        rd(uart_stat_pkg::ADDR_MODEM_S, 32'h0);
        rd(8'h0c, 32'h0);
        chk({31'h0, e}, 32'h1);
        v = 8'($urandom);
        apb(1'b1, uart_stat_pkg::ADDR_SCRATCH, v);
        rd(uart_stat_pkg::ADDR_SCRATCH, {24'h0, v});
        apb(1'b1, uart_stat_pkg::ADDR_FIFOCTL, 8'h01);
        for (int i = 0; i < 17; i++) push(uart_stat_pkg::rx_char_s'({1'b0, 10'($urandom)}));
        rd(uart_stat_pkg::ADDR_LINE_ST, ls_exp(1'b1, 2'b11));
        rd(uart_stat_pkg::ADDR_LINE_ST, ls_exp(1'b0, 2'b11));
        while (fq.size() > 0) begin
            rd(uart_stat_pkg::ADDR_LINE_ST, ls_exp(1'b0, 2'b11));
            pop();
        end
        rd(uart_stat_pkg::ADDR_LINE_ST, ls_exp(1'b0, 2'b11));
        push('{1'b1, 1'b0, 1'b0, 8'h00});
        push('{1'b1, 1'b0, 1'b0, 8'h00});
        push('{1'b0, 1'b0, 1'b0, 8'h5a});
        rd(uart_stat_pkg::ADDR_LINE_ST, ls_exp(1'b0, 2'b11));
        pop();
        pop();
        hold <= 1'b1;
        apb(1'b1, uart_stat_pkg::ADDR_DATA, v);
        rd(uart_stat_pkg::ADDR_LINE_ST, ls_exp(1'b0, 2'b00));
        hold <= 1'b0;
        repeat (6) @(posedge mclk);
        rd(uart_stat_pkg::ADDR_LINE_ST, ls_exp(1'b0, 2'b01));
        chk({24'h0, model.last_tx}, {24'h0, v});
        repeat (40) @(posedge mclk);
        rd(uart_stat_pkg::ADDR_LINE_ST, ls_exp(1'b0, 2'b11));
        apb(1'b1, uart_stat_pkg::ADDR_IENABLE, 8'h08);
        apb(1'b1, uart_stat_pkg::ADDR_MODEM_C, 8'h1b);
        repeat (3) @(posedge mclk);
        chk({31'h0, irq}, 32'h1);
        rd(uart_stat_pkg::ADDR_MODEM_S, 32'hbb);
        rd(uart_stat_pkg::ADDR_MODEM_S, 32'hb0);
        apb(1'b1, uart_stat_pkg::ADDR_MODEM_C, 8'h14);
        repeat (3) @(posedge mclk);
        rd(uart_stat_pkg::ADDR_MODEM_S, 32'h4b);
        apb(1'b1, uart_stat_pkg::ADDR_IENABLE, 8'h00);
        apb(1'b1, uart_stat_pkg::ADDR_MODEM_C, 8'h10);
        repeat (3) @(posedge mclk);
        chk({31'h0, irq}, 32'h0);
        rd(uart_stat_pkg::ADDR_MODEM_S, 32'h04);
        apb(1'b1, uart_stat_pkg::ADDR_FEATURE, 8'h40);
        hold <= 1'b1;
        apb(1'b1, uart_stat_pkg::ADDR_DATA, 8'h11);
        apb(1'b1, uart_stat_pkg::ADDR_DATA, 8'h22);
        repeat (3) push(uart_stat_pkg::rx_char_s'({3'h0, 8'($urandom)}));
        for (int m = 0; m < 3; m++) begin
            apb(1'b1, uart_stat_pkg::ADDR_SCRATCH, 8'(m == 2 ? 1 : m * 2));
            rd(uart_stat_pkg::ADDR_SCRATCH, (m == 2) ? 32'h2 : 32'h3);
        end
        apb(1'b1, uart_stat_pkg::ADDR_SCRATCH, 8'h03);
        for (int m = 0; m < 4; m++) rd(uart_stat_pkg::ADDR_SCRATCH, 32'(3 - m % 2));
        for (int c = 0; c < 16; c++) begin
            apb(1'b1, uart_stat_pkg::ADDR_SCRATCH, {2'b00, 2'(c >> 2), 4'h0});
            apb(1'b1, uart_stat_pkg::ADDR_FEATURE, {6'h10, 2'(c)});
            repeat (2) @(posedge mclk);
            chk({26'h0, hyst}, hyst_exp(4'(c)));
        end
        apb(1'b1, uart_stat_pkg::ADDR_FEATURE, 8'h00);
        rd(uart_stat_pkg::ADDR_SCRATCH, {24'h0, v});
        repeat (3) pop();
        hold <= 1'b0;
        apb(1'b1, uart_stat_pkg::ADDR_MODEM_C, 8'h80);
        ticks(8);
        apb(1'b1, uart_stat_pkg::ADDR_ENHFUNC, 8'h10);
        apb(1'b1, uart_stat_pkg::ADDR_MODEM_C, 8'h80);
        repeat (4) @(posedge mclk);
        ticks(2);
        complete_run();
    end
endmodule
